/* File: sacr_defines.vh */
// Constants for the converter conversion and serial readout control
`ifndef SACR_DEFINES_VH
`define SACR_DEFINES_VH
// ----------------------------------------
// Word layout
// ----------------------------------------
`define SACR_WORD_BITS 16
`define SACR_MSB 15
`define SACR_CNT_W 5
// ----------------------------------------
// Synchronised pin positions
// ----------------------------------------
`define SACR_PIN_COUNT 6
`define SACR_PIN_CS 0
`define SACR_PIN_RC 1
`define SACR_PIN_EXT 2
`define SACR_PIN_SCK 3
`define SACR_PIN_TAG 4
`define SACR_PIN_FMT 5
// ----------------------------------------
// Times in ns and derived counts at 8 ns
// ----------------------------------------
`define SACR_CLK_NS 8
`define SACR_CONV_NS 2200
`define SACR_CONV_CYC ((`SACR_CONV_NS) / (`SACR_CLK_NS))
`define SACR_SCK_DELAY_NS 270
`define SACR_SCK_DELAY_CYC (((`SACR_SCK_DELAY_NS) + (`SACR_CLK_NS) - 1) / (`SACR_CLK_NS))
`define SACR_SCK_PERIOD_NS 110
`define SACR_SCK_HALF_CYC ((`SACR_SCK_PERIOD_NS) / (2 * (`SACR_CLK_NS)))
`define SACR_DATA_AVAIL_NS 2000
`define SACR_DATA_AVAIL_CYC (((`SACR_DATA_AVAIL_NS) + (`SACR_CLK_NS) - 1) / (`SACR_CLK_NS))
`define SACR_TIMER_W 9
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SACR_WORD_RST 16'h0000
`define SACR_TIMER_RST 9'h000
`define SACR_BITS_RST 5'h00
`endif

/* File: sacr_core.v */
// Conversion start, busy, and serial readout control of a 16-bit converter
`timescale 1ns/1ps
`include "sacr_defines.vh"
// What this block does
// - With device select low, a falling read_convert edge holds the sample and starts a conversion.
// - In internal clock mode that start edge also begins sending the previous result.
// - In external mode a read edge (rc rise with select low, select fall with rc high) starts a readout and takes any armed sync.
// - Words come out straight binary with format_select high, two's complement when low.
// - A frame pulse comes only in external mode after a shift clock edge outside the read state.
// - In external mode the cascade input is passed to the data output behind the word.
// - Busy stays low at most 2.2 us per conversion.
// - In internal mode the shift clock starts about 270 ns after read_convert falls.
// - The internal shift clock has a period of 96 ns, 6 clocks high and 6 low.
// - The previous result is readable no earlier than 2 us after select and rc are both low.
// - Busy falls at conversion start and rises once the result sits in the output register.
// - In internal mode exactly 16 shift clock pulses follow each start, then the clock idles low.
// - In external mode the shift clock is an input and output follows the host clock.
// - In external mode after 16 bits the cascade level is output while select low and rc high.
module sacr_core (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Control pins
   input wire device_select_n_i,
   input wire read_convert_i,
   input wire clock_source_select_i,
   input wire format_select_i,
   input wire cascade_input_i,
   // Conversion result from the converter core
   input wire [15:0] sample_code_i,
   // Shift clock pin, two-way
   input wire shift_clock_i,
   output reg shift_clock_o,
   output wire shift_clock_oe_o,
   // Status and serial outputs
   output reg busy_n_o,
   output reg frame_pulse_o,
   output reg serial_data_o,
   output wire data_ready_o
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Every pin passes two flip-flops before any logic reads it
   wire [`SACR_PIN_COUNT-1:0] pin_raw;
   wire [`SACR_PIN_COUNT-1:0] pin_sync;
   assign pin_raw[`SACR_PIN_CS] = device_select_n_i;
   assign pin_raw[`SACR_PIN_RC] = read_convert_i;
   assign pin_raw[`SACR_PIN_EXT] = clock_source_select_i;
   assign pin_raw[`SACR_PIN_SCK] = shift_clock_i;
   assign pin_raw[`SACR_PIN_TAG] = cascade_input_i;
   assign pin_raw[`SACR_PIN_FMT] = format_select_i;
   genvar g;
   generate
      for (g = 0; g < `SACR_PIN_COUNT; g = g + 1) begin : g_sync
         reg stage_a;
         reg stage_b;
         always @(posedge clk_i) begin
            stage_a <= pin_raw[g];
            stage_b <= stage_a;
         end
         assign pin_sync[g] = stage_b;
      end
   endgenerate
   wire cs_n = pin_sync[`SACR_PIN_CS];
   wire rc = pin_sync[`SACR_PIN_RC];
   wire ext_mode = pin_sync[`SACR_PIN_EXT];
   wire sck = pin_sync[`SACR_PIN_SCK];
   wire tag = pin_sync[`SACR_PIN_TAG];
   wire fmt_straight = pin_sync[`SACR_PIN_FMT];
   // ----------------------------------------
   // Edge detection
   // ----------------------------------------
   // Previous levels start at the inactive level so that reset gives no false edge
   reg cs_d;
   reg rc_d;
   reg sck_d;
   always @(posedge clk_i) begin
      if (rst_i) begin
         cs_d <= 1'b1;
         rc_d <= 1'b1;
         sck_d <= 1'b0;
      end else begin
         cs_d <= cs_n;
         rc_d <= rc;
         sck_d <= sck;
      end
   end
   // Internally ORed select and read_convert
   wire ored = cs_n | rc;
   wire ored_d = cs_d | rc_d;
   wire conv_start = ored_d & ~ored;
   wire read_start = ext_mode & ~cs_n & rc & (~rc_d | cs_d);
   wire read_state = ext_mode & ~cs_n & rc;
   wire sck_rise = ext_mode & sck & ~sck_d;
   // ----------------------------------------
   // Format conversion
   // ----------------------------------------
   function [15:0] fmt_word;
      input [15:0] code;
      input straight;
      begin
         fmt_word = straight ? code : {~code[15], code[14:0]};
      end
   endfunction
   // ----------------------------------------
   // Readout helpers
   // ----------------------------------------
   function [15:0] shift_word;
      input [15:0] word;
      input fill;
      begin
         shift_word = {word[`SACR_MSB-1:0], fill};
      end
   endfunction
   function is_last_bit;
      input [`SACR_CNT_W-1:0] count;
      begin
         is_last_bit = (count == `SACR_WORD_BITS - 1);
      end
   endfunction
   // ----------------------------------------
   // Conversion timer and busy
   // ----------------------------------------
   reg [`SACR_TIMER_W-1:0] conv_cnt;
   reg [`SACR_TIMER_W-1:0] avail_cnt;
   reg [15:0] result;
   reg next_busy_n;
   reg [`SACR_TIMER_W-1:0] next_conv_cnt;
   reg [15:0] next_result;
   wire conv_done = (conv_cnt == `SACR_CONV_CYC - 1);
   always @* begin
      next_busy_n = busy_n_o;
      next_conv_cnt = conv_cnt;
      next_result = result;
      if (conv_start && busy_n_o) begin
         next_busy_n = 1'b0;
         next_conv_cnt = `SACR_TIMER_RST;
      end else if (!busy_n_o) begin
         if (conv_done) begin
            next_busy_n = 1'b1;
            next_result = fmt_word(sample_code_i, fmt_straight);
         end else begin
            next_conv_cnt = conv_cnt + 9'h001;
         end
      end
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         busy_n_o <= 1'b1;
         conv_cnt <= `SACR_TIMER_RST;
         result <= `SACR_WORD_RST;
      end else begin
         busy_n_o <= next_busy_n;
         conv_cnt <= next_conv_cnt;
         result <= next_result;
      end
   end
   // ----------------------------------------
   // Previous-data availability
   // ----------------------------------------
   reg [`SACR_TIMER_W-1:0] next_avail_cnt;
   always @* begin
      next_avail_cnt = avail_cnt;
      if (ored) begin
         next_avail_cnt = `SACR_TIMER_RST;
      end else if (avail_cnt != `SACR_DATA_AVAIL_CYC) begin
         next_avail_cnt = avail_cnt + 9'h001;
      end
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         avail_cnt <= `SACR_TIMER_RST;
      end else begin
         avail_cnt <= next_avail_cnt;
      end
   end
   assign data_ready_o = ~ored & (avail_cnt == `SACR_DATA_AVAIL_CYC);
   // ----------------------------------------
   // Serial readout
   // ----------------------------------------
   localparam ST_IDLE = 3'h0;
   localparam ST_WAIT = 3'h1;
   localparam ST_INT = 3'h2;
   localparam ST_EXT = 3'h3;
   localparam ST_TAG = 3'h4;
   reg [2:0] state;
   reg [15:0] shreg;
   reg [`SACR_CNT_W-1:0] bit_cnt;
   reg [`SACR_TIMER_W-1:0] tmr;
   reg tag_held;
   reg armed;
   reg sync_pend;
   assign shift_clock_oe_o = ~ext_mode;
   // ----------------------------------------
   // Timer end points
   // ----------------------------------------
   wire delay_done = (tmr == `SACR_SCK_DELAY_CYC - 1);
   wire half_done = (tmr == `SACR_SCK_HALF_CYC - 1);
   // ----------------------------------------
   // Sync arming
   // ----------------------------------------
   // A host clock edge outside the read state arms one pulse; the read that takes it disarms
   always @(posedge clk_i) begin
      if (rst_i) begin
         armed <= 1'b0;
      end else if (sck_rise && !read_state) begin
         armed <= 1'b1;
      end else if (read_start && state == ST_IDLE) begin
         armed <= 1'b0;
      end
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         shreg <= `SACR_WORD_RST;
         bit_cnt <= `SACR_BITS_RST;
         tmr <= `SACR_TIMER_RST;
         tag_held <= 1'b0;
         sync_pend <= 1'b0;
         shift_clock_o <= 1'b0;
         frame_pulse_o <= 1'b0;
         serial_data_o <= 1'b0;
      end else begin
         frame_pulse_o <= 1'b0;
         case (state)
            ST_IDLE: begin
               shift_clock_o <= 1'b0;
               serial_data_o <= tag_held;
               if (!ext_mode && conv_start) begin
                  shreg <= result;
                  tag_held <= tag;
                  tmr <= 9'h000;
                  state <= ST_WAIT;
               end else if (read_start) begin
                  shreg <= result;
                  bit_cnt <= 5'h00;
                  sync_pend <= armed;
                  state <= ST_EXT;
               end
            end
            ST_WAIT: begin
               if (delay_done) begin
                  tmr <= 9'h000;
                  bit_cnt <= 5'h00;
                  serial_data_o <= shreg[`SACR_MSB];
                  state <= ST_INT;
               end else begin
                  tmr <= tmr + 9'h001;
               end
            end
            ST_INT: begin
               if (half_done) begin
                  tmr <= 9'h000;
                  shift_clock_o <= ~shift_clock_o;
                  if (shift_clock_o) begin
                     shreg <= shift_word(shreg, 1'b0);
                     if (is_last_bit(bit_cnt)) begin
                        serial_data_o <= tag_held;
                        state <= ST_IDLE;
                     end else begin
                        bit_cnt <= bit_cnt + 5'h01;
                        serial_data_o <= shreg[14];
                     end
                  end
               end else begin
                  tmr <= tmr + 9'h001;
               end
            end
            ST_EXT: begin
               if (!read_state) begin
                  state <= ST_IDLE;
               end else if (sck_rise) begin
                  if (sync_pend) begin
                     frame_pulse_o <= 1'b1;
                     sync_pend <= 1'b0;
                  end else begin
                     serial_data_o <= shreg[`SACR_MSB];
                     shreg <= shift_word(shreg, tag);
                     if (is_last_bit(bit_cnt)) begin
                        state <= ST_TAG;
                     end else begin
                        bit_cnt <= bit_cnt + 5'h01;
                     end
                  end
               end
            end
            ST_TAG: begin
               if (!read_state) begin
                  state <= ST_IDLE;
               end else if (sck_rise) begin
                  serial_data_o <= shreg[`SACR_MSB];
                  shreg <= shift_word(shreg, tag);
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

/* File: sacr_core_chk.sv */
// Assertion checker for the conversion and serial readout control
`timescale 1ns/1ps
module sacr_core_chk (
   input logic clk_i,
   input logic rst_i,
   input logic device_select_n_i,
   input logic read_convert_i,
   input logic clock_source_select_i,
   input logic shift_clock_o,
   input logic shift_clock_oe_o,
   input logic busy_n_o,
   input logic frame_pulse_o,
   input logic data_ready_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_start; $fell(busy_n_o) |-> !$past(read_convert_i, 2) && !$past(device_select_n_i, 2); endproperty
   a_start: assert property (p_start) else $error("busy fell without a start");
   property p_busy_max; $fell(busy_n_o) |-> ##[1:280] busy_n_o; endproperty
   a_busy_max: assert property (p_busy_max) else $error("busy low too long");
   property p_busy_min; $fell(busy_n_o) |=> !busy_n_o [*8]; endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy high too early");
   property p_frame; frame_pulse_o |-> !shift_clock_oe_o ##1 !frame_pulse_o; endproperty
   a_frame: assert property (p_frame) else $error("bad frame pulse");
   property p_sck_delay; $fell(busy_n_o) && shift_clock_oe_o |-> !shift_clock_o [*8]; endproperty
   a_sck_delay: assert property (p_sck_delay) else $error("shift clock too early");
   property p_sck_half; $rose(shift_clock_o) |-> shift_clock_o [*6] ##1 !shift_clock_o; endproperty
   a_sck_half: assert property (p_sck_half) else $error("shift clock high time");
   property p_oe; clock_source_select_i [*4] |-> !shift_clock_oe_o; endproperty
   a_oe: assert property (p_oe) else $error("shift clock driven in external mode");
   property p_ready; $rose(data_ready_o) |-> !$past(read_convert_i, 240); endproperty
   a_ready: assert property (p_ready) else $error("data ready too early");
   c_conv: cover property ($fell(busy_n_o));
   c_sync: cover property (frame_pulse_o);
   c_ready: cover property ($rose(data_ready_o));
endmodule
bind sacr_core sacr_core_chk u_chk (.*);

/* File: sacr_host.sv */
// Host serial port model: drives the external shift clock and reads words
`timescale 1ns/1ps
module sacr_host (
   // Clock and observed pins
   input wire logic clk_i,
   input wire logic shift_clock_i,
   input wire logic serial_data_i,
   input wire logic frame_pulse_i,
   // Host shift clock drive
   output logic host_clock_o
);
   logic [19:0] word = 20'h00000;
   int sync_cnt = 0;
   event got;
   initial host_clock_o = 1'b0;
   always @(posedge clk_i) if (frame_pulse_i) sync_cnt <= sync_cnt + 1;
   // One 80 ns pulse (40 ns high) off the bench clock phase; data is taken on a falling bench clock edge, clear of the rising edges
   task automatic pulse(input bit take);
      #3 host_clock_o = 1'b1;
      #40 host_clock_o = 1'b0;
      #33 if (take) word = {word[18:0], serial_data_i};
      #4;
   endtask
   // Read after conversion, with a leading sync pulse when armed
   task automatic ext_read(input bit sync);
      word = 20'h00000;
      if (sync) pulse(1'b0);
      repeat (20) pulse(1'b1);
      -> got;
   endtask
   task automatic int_read;
      word = 20'h00000;
      repeat (16) begin
         @(posedge shift_clock_i);
         word = {word[18:0], serial_data_i};
      end
      -> got;
   endtask
endmodule

/* File: sacr_core_bench.sv */
// Self-checking bench for the conversion and serial readout control
`timescale 1ns/1ps
module sacr_core_bench;
   logic clk_i = 1'b0, rst_i = 1'b1, cs_n = 1'b0, rc = 1'b1, ext = 1'b0, fmt = 1'b1, tag = 1'b0;
   logic [15:0] code = 16'h0000, res;
   logic sck_o, sck_oe, busy_n, frame, sdata, ready, host_clk, pin;
   logic [19:0] q[$];
   int fail_count = 0, checks = 0, seed = 14743, n;
   assign pin = sck_oe ? sck_o : host_clk;
   sacr_core dut (.clk_i(clk_i), .rst_i(rst_i), .device_select_n_i(cs_n), .read_convert_i(rc),
      .clock_source_select_i(ext), .format_select_i(fmt), .cascade_input_i(tag),
      .sample_code_i(code), .shift_clock_i(pin), .shift_clock_o(sck_o),
      .shift_clock_oe_o(sck_oe), .busy_n_o(busy_n), .frame_pulse_o(frame),
      .serial_data_o(sdata), .data_ready_o(ready));
   sacr_host host (.clk_i(clk_i), .shift_clock_i(pin), .serial_data_i(sdata),
      .frame_pulse_i(frame), .host_clock_o(host_clk));
   initial forever #4 clk_i = ~clk_i;
   task automatic check(input logic [19:0] got, input logic [19:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wait_busy(input logic lvl);
      int k = 0;
      while (busy_n !== lvl && k < 400) begin
         @(posedge clk_i);
         k++;
      end
      if (k == 400) check(busy_n, lvl);
   endtask
   initial forever @(host.got) check(host.word, q.pop_front());
   initial begin
      #200000 fail_count++;
      stop_test;
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         code <= 16'($random(seed));
         fmt <= 1'($random(seed));
         if (i > 0 && i < 4) q.push_back({4'h0, res});
         @(posedge clk_i) rc <= 1'b0;
         repeat (4) @(posedge clk_i);
         cs_n <= 1'b0;
         wait_busy(1'b0);
         check(ready, 1'b0);
         if (i > 0 && i < 4) host.int_read;
         wait_busy(1'b1);
         check(ready, 1'b1);
         res = fmt ? code : {~code[15], code[14:0]};
         if (i > 3) begin
            tag <= 1'($random(seed));
            if (i[0]) cs_n <= 1'b1;
            rc <= 1'b1;
            repeat (4) @(posedge clk_i);
            if (i[0]) host.pulse(1'b0);
            @(posedge clk_i) cs_n <= 1'b0;
            n = host.sync_cnt;
            q.push_back({res, {4{tag}}});
            repeat (4) @(posedge clk_i);
            host.ext_read(i[0]);
            check(20'(host.sync_cnt - n), 20'(i[0]));
         end
         @(posedge clk_i) rc <= 1'b1;
         cs_n <= (i >= 3);
         ext <= (i >= 3);
         repeat (4) @(posedge clk_i);
      end
      stop_test;
   end
endmodule
